// *** inc/cap_params_pkg.sv ***
/*
 * Constants, field layouts and register offsets of the capability parameter bank.
 * Assumes a host function memory window decoded upstream; offsets are byte addresses.
 */
`default_nettype none
package cap_params_pkg;

    // Register byte offsets within the host function memory window
    localparam logic [7:0] STRUCT_PARAMS_OFS = 8'h04;
    localparam logic [7:0] CAP_PARAMS_OFS    = 8'h08;
    localparam logic [7:0] ROUTE_LO_OFS      = 8'h0C;
    localparam logic [7:0] ROUTE_HI_OFS      = 8'h10;
    localparam logic [7:0] HOST_CMD_OFS      = 8'h20;

    // Structural parameter field positions
    localparam int PORT_COUNT_LSB      = 0;
    localparam int PORT_POWER_BIT      = 4;
    localparam int ROUTING_RULE_BIT    = 7;
    localparam int PORTS_PER_COMP_LSB  = 8;
    localparam int COMPANION_COUNT_LSB = 12;

    // Capability parameter field positions
    localparam int WIDE_ADDR_BIT       = 0;
    localparam int PROG_FLIST_BIT      = 1;
    localparam int ISO_THRESH_LSB      = 4;

    // Host command register frame list size field
    localparam int FLS_LSB             = 2;

    // Fixed capability values
    localparam logic [3:0] PORT_COUNT_VAL      = 4'h4;
    localparam logic       PORT_POWER_VAL      = 1'b1;
    localparam logic       ROUTING_RULE_VAL    = 1'b1;
    localparam logic [3:0] PORTS_PER_COMP_VAL  = 4'h2;
    localparam logic [3:0] COMPANION_COUNT_VAL = 4'h2;
    localparam logic [3:0] ISO_THRESH_VAL      = 4'h1;
    localparam logic       PROG_FLIST_VAL      = 1'b1;
    localparam logic       WIDE_ADDR_VAL       = 1'b0;

    // Count never presented as zero
    localparam logic [3:0] PORT_COUNT_SAFE = (PORT_COUNT_VAL == 4'h0) ? 4'h1 : PORT_COUNT_VAL;
    localparam logic [3:0] PPC_SAFE = (PORTS_PER_COMP_VAL == 4'h0) ? 4'h1 : PORTS_PER_COMP_VAL;

    // Explicit route array: element i at bits 4*i+3 .. 4*i
    localparam int          ROUTE_ELEMS   = 15;
    localparam logic [59:0] ROUTE_ARR_VAL = 60'h000_0000_0000_1100;

    // Frame list sizes selected by the frame list size field
    localparam logic [1:0]  FLS_1024     = 2'h0;
    localparam logic [1:0]  FLS_512      = 2'h1;
    localparam logic [1:0]  FLS_256      = 2'h2;
    localparam logic [1:0]  FLS_RESET    = 2'h0;
    localparam logic [10:0] FLIST_1024   = 11'h400;
    localparam logic [10:0] FLIST_512    = 11'h200;
    localparam logic [10:0] FLIST_256    = 11'h100;

    typedef struct packed {
        logic [7:0]  reserved_hi;
        logic [3:0]  debug_port;
        logic [3:0]  reserved_mid;
        logic [3:0]  companion_count;
        logic [3:0]  ports_per_companion;
        logic        routing_rule_select;
        logic [1:0]  reserved_lo;
        logic        port_power_switch_cap;
        logic [3:0]  port_count;
    } structural_parameters_t;

    typedef struct packed {
        logic [23:0] reserved_hi;
        logic [3:0]  iso_sched_threshold;
        logic [1:0]  reserved_lo;
        logic        programmable_frame_list_flag;
        logic        wide_addressing_cap;
    } capability_parameters_t;

    localparam structural_parameters_t STRUCT_RESET = '{
        reserved_hi: 8'h00, debug_port: 4'h0, reserved_mid: 4'h0,
        companion_count: COMPANION_COUNT_VAL, ports_per_companion: PPC_SAFE,
        routing_rule_select: ROUTING_RULE_VAL, reserved_lo: 2'h0,
        port_power_switch_cap: PORT_POWER_VAL, port_count: PORT_COUNT_SAFE};

    localparam capability_parameters_t CAP_RESET = '{
        reserved_hi: 24'h000000, iso_sched_threshold: ISO_THRESH_VAL, reserved_lo: 2'h0,
        programmable_frame_list_flag: PROG_FLIST_VAL, wide_addressing_cap: WIDE_ADDR_VAL};

endpackage
`default_nettype wire

// *** core/port_route_map.sv ***
/*
 * Companion owner of one downstream port.
 * Assumes constant port index; routing inputs steady from the register bank.
 */
`timescale 1ns/10ps
`default_nettype none
module port_route_map
    import cap_params_pkg::*;
#(
    parameter int PORT_IDX = 0
) (
    // Routing configuration
    input  wire logic       rule_sel,
    input  wire logic [3:0] route_elem,
    input  wire logic [3:0] port_count,
    // Result
    output logic      [3:0] owner,
    output logic            present
);
    localparam logic [3:0] GROUP_IDX = 4'(PORT_IDX / int'(PPC_SAFE));
    localparam logic [3:0] IDX4      = 4'(PORT_IDX);

    wire logic in_range = IDX4 < port_count;

    assign present = in_range;
    assign owner   = !in_range ? 4'h0 : (rule_sel ? route_elem : GROUP_IDX);
endmodule // port_route_map
`default_nettype wire

// *** core/cap_param_regs.sv ***
/*
 * Read-only capability and structural parameter registers of the high-speed host function,
 * with the frame list size field of the host command register and port routing outputs.
 * Assumes a decoded memory target access: one-cycle rd_en/wr_en strobes with byte address.
 * A read in the cycle of a write returns the value held before that write.
 * The reserved frame list size code is dropped on write.
 */
// Functional notes
// - Routing rule 0: consecutive groups of ports-per-companion go to successive companions.
// - Routing rule 1: each port follows its explicit route array element.
// - Structural bit 4 reads 1 with port power switches, 0 without.
// - Port power capability governs behaviour of each port power field.
// - Bits 3..0 give port count; count fixes addressable per-port registers.
// - Port count lies in 1h..Fh; zero never presented.
// - Capability register is 32-bit read-only at offset 08h.
// - Bits 7..4 give isochronous scheduling threshold in micro-frames or whole frame.
// - Without programmable frame list, frame list size bits 3..2 read zero.
// - With programmable frame list, software's shorter size selection is honoured.
// - Bit 0 reports 32-bit (0) or 64-bit (1) pointers.
// - Ports-per-companion in bits 11..8, consistent with port and companion counts.
// - Route array holds fifteen 4-bit companion indexes, one per port.
`timescale 1ns/10ps
`default_nettype none
module cap_param_regs
    import cap_params_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Register access
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [7:0]  addr,
    input  wire logic [3:0]  byte_en,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] rd_data_r,
    output logic             rd_valid_r,
    // Port side
    output logic      [59:0] port_owner_r,
    output logic      [14:0] port_present_r,
    output logic             port_power_ctrl_r,
    output logic      [1:0]  frame_list_size_r,
    output logic      [10:0] frame_list_entries_r,
    output logic             wide_pointers_r,
    output logic      [3:0]  iso_sched_threshold_r,
    output logic             iso_full_frame_r
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter images

    structural_parameters_t struct_r;
    structural_parameters_t struct_nxt;
    capability_parameters_t cap_r;
    capability_parameters_t cap_nxt;
    logic [59:0]            route_r;
    logic [1:0]             fls_r;
    logic [1:0]             fls_nxt;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            struct_r <= STRUCT_RESET;
            cap_r    <= CAP_RESET;
            route_r  <= ROUTE_ARR_VAL;
        end else begin
            struct_r <= struct_nxt;
            cap_r    <= cap_nxt;
            route_r  <= ROUTE_ARR_VAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Image next values, reserved fields held at zero

    always_comb begin
        struct_nxt                       = structural_parameters_t'(32'h00000000);
        struct_nxt.companion_count       = COMPANION_COUNT_VAL;
        struct_nxt.ports_per_companion   = PPC_SAFE;
        struct_nxt.routing_rule_select   = ROUTING_RULE_VAL;
        struct_nxt.port_power_switch_cap = PORT_POWER_VAL;
        struct_nxt.port_count            = PORT_COUNT_SAFE;
    end

    always_comb begin
        cap_nxt                              = capability_parameters_t'(32'h00000000);
        cap_nxt.iso_sched_threshold          = ISO_THRESH_VAL;
        cap_nxt.programmable_frame_list_flag = PROG_FLIST_VAL;
        cap_nxt.wide_addressing_cap          = WIDE_ADDR_VAL;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire logic hit_struct = addr == STRUCT_PARAMS_OFS;
    wire logic hit_cap    = addr == CAP_PARAMS_OFS;
    wire logic hit_rt_lo  = addr == ROUTE_LO_OFS;
    wire logic hit_rt_hi  = addr == ROUTE_HI_OFS;
    wire logic hit_cmd    = addr == HOST_CMD_OFS;

    wire logic prog_flist = cap_r.programmable_frame_list_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame list size field

    wire logic [1:0] fls_wr_val = wr_data[FLS_LSB +: 2];
    wire logic       fls_wr_hit = wr_en && hit_cmd && byte_en[0];
    wire logic       fls_wr_ok  = fls_wr_val != 2'h3;
    wire logic       fls_wr     = fls_wr_hit && fls_wr_ok;

    always_comb begin
        fls_nxt = fls_r;
        if (!prog_flist) begin
            fls_nxt = FLS_1024;
        end else if (fls_wr) begin
            fls_nxt = fls_wr_val;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fls_r <= FLS_RESET;
        end else begin
            fls_r <= fls_nxt;
        end
    end

    wire logic [10:0] flist_entries = (fls_r == FLS_512) ? FLIST_512 :
                                      (fls_r == FLS_256) ? FLIST_256 : FLIST_1024;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    wire logic [31:0] struct_word   = 32'(struct_r);
    wire logic [31:0] cap_word      = 32'(cap_r);
    wire logic [31:0] route_lo_word = route_r[31:0];
    wire logic [31:0] route_hi_word = {4'h0, route_r[59:32]};
    wire logic [31:0] cmd_word      = {28'h0000000, fls_r, 2'h0};
    wire logic [31:0] rd_select     = hit_struct ? struct_word :
                                      hit_cap    ? cap_word :
                                      hit_rt_lo  ? route_lo_word :
                                      hit_rt_hi  ? route_hi_word :
                                      hit_cmd    ? cmd_word : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // Read answer

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r  <= 32'h00000000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r  <= rd_en ? rd_select : 32'h00000000;
            rd_valid_r <= rd_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port routing

    logic [59:0] owner_w;
    logic [14:0] present_w;

    genvar gi;
    generate
        for (gi = 0; gi < ROUTE_ELEMS; gi = gi + 1) begin : g_port
            port_route_map #(
                .PORT_IDX (gi)
            ) u_map (
                .rule_sel   (struct_r.routing_rule_select),
                .route_elem (route_r[4*gi +: 4]),
                .port_count (struct_r.port_count),
                .owner      (owner_w[4*gi +: 4]),
                .present    (present_w[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Port side outputs

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_owner_r      <= 60'h000000000000000;
            port_present_r    <= 15'h0000;
            port_power_ctrl_r <= 1'b0;
        end else begin
            port_owner_r      <= owner_w;
            port_present_r    <= present_w;
            port_power_ctrl_r <= struct_r.port_power_switch_cap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame list outputs

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_list_size_r    <= FLS_RESET;
            frame_list_entries_r <= FLIST_1024;
        end else begin
            frame_list_size_r    <= fls_r;
            frame_list_entries_r <= flist_entries;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Isochronous and addressing outputs

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wide_pointers_r       <= 1'b0;
            iso_sched_threshold_r <= 4'h0;
            iso_full_frame_r      <= 1'b0;
        end else begin
            wide_pointers_r       <= cap_r.wide_addressing_cap;
            iso_sched_threshold_r <= {1'b0, cap_r.iso_sched_threshold[2:0]};
            iso_full_frame_r      <= cap_r.iso_sched_threshold[3];
        end
    end

endmodule // cap_param_regs
`default_nettype wire

// *** testbench/cap_param_regs_sva.sv ***
/* Concurrent checks on the capability parameter bank ports.
   Assumes binding onto cap_param_regs and one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module cap_param_regs_sva
    import cap_params_pkg::*;
(
    // Clock, reset, access
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        rd_en,
    input wire logic        wr_en,
    input wire logic [7:0]  addr,
    input wire logic [3:0]  byte_en,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] rd_data_r,
    input wire logic        rd_valid_r,
    // Port side
    input wire logic [59:0] port_owner_r,
    input wire logic [14:0] port_present_r,
    input wire logic        port_power_ctrl_r,
    input wire logic [1:0]  frame_list_size_r,
    input wire logic [10:0] frame_list_entries_r,
    input wire logic        wide_pointers_r,
    input wire logic [3:0]  iso_sched_threshold_r,
    input wire logic        iso_full_frame_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(a); rd_en && addr == a; endsequence
    sequence s_fls_wr; wr_en && addr == HOST_CMD_OFS && byte_en[0] && wr_data[3:2] != 2'h3;
    endsequence
    AST_RD_ANSWER: assert property (rd_en |=> rd_valid_r) else $error("read unanswered");
    AST_RD_IDLE: assert property (
        !rd_en |=> !rd_valid_r && rd_data_r == 32'h0)
        else $error("spurious read data");
    AST_CAP_IMAGE: assert property (
        s_rd(CAP_PARAMS_OFS) |=> rd_data_r == 32'h0000_0012)
        else $error("capability image wrong");
    AST_STRUCT_IMAGE: assert property (
        s_rd(STRUCT_PARAMS_OFS) |=> rd_data_r == 32'h0000_2294)
        else $error("structural image wrong");
    AST_ROUTE_IMAGE: assert property (
        s_rd(ROUTE_LO_OFS) |=> rd_data_r == 32'h0000_1100)
        else $error("route image wrong");
    AST_FLS_TAKE: assert property (
        s_fls_wr ##1 !wr_en |=> frame_list_size_r == $past(wr_data[3:2], 2))
        else $error("frame list size not taken");
    AST_FLS_ENTRIES: assert property ($past(reset_n) |-> frame_list_entries_r ==
        (frame_list_size_r == 2'h1 ? 11'h200 : frame_list_size_r == 2'h2 ? 11'h100 : 11'h400))
        else $error("frame list entries wrong");
    AST_PORTS: assert property ($past(reset_n) |-> port_present_r == 15'h000F
        && port_owner_r == 60'h1100) else $error("port map wrong");
    AST_CAPS: assert property ($past(reset_n) |-> port_power_ctrl_r && !wide_pointers_r
        && iso_sched_threshold_r == 4'h1 && !iso_full_frame_r) else $error("caps wrong");
endmodule // cap_param_regs_sva
bind cap_param_regs cap_param_regs_sva u_sva (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .rd_en                 (rd_en),
    .wr_en                 (wr_en),
    .addr                  (addr),
    .byte_en               (byte_en),
    .wr_data               (wr_data),
    .rd_data_r             (rd_data_r),
    .rd_valid_r            (rd_valid_r),
    .port_owner_r          (port_owner_r),
    .port_present_r        (port_present_r),
    .port_power_ctrl_r     (port_power_ctrl_r),
    .frame_list_size_r     (frame_list_size_r),
    .frame_list_entries_r  (frame_list_entries_r),
    .wide_pointers_r       (wide_pointers_r),
    .iso_sched_threshold_r (iso_sched_threshold_r),
    .iso_full_frame_r      (iso_full_frame_r)
);
`default_nettype wire

// *** testbench/cap_param_regs_tb_top.sv ***
/* Directed test of the capability parameter bank.
   Assumes the one-cycle read answer and strobe protocol of the bank. */
`timescale 1ns/10ps
`default_nettype none
module cap_param_regs_tb_top import cap_params_pkg::*;;
    logic sys_clk = 0, reset_n = 0, rd_en = 0, wr_en = 0;
    logic [7:0] addr = 8'h00;
    logic [3:0] byte_en = 4'h0;
    logic [31:0] wr_data = 32'h0, rd_data_r;
    logic rd_valid_r, port_power_ctrl_r, wide_pointers_r, iso_full_frame_r;
    logic [59:0] port_owner_r;
    logic [14:0] port_present_r;
    logic [1:0] frame_list_size_r;
    logic [10:0] frame_list_entries_r;
    logic [3:0] iso_sched_threshold_r;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    localparam logic [7:0] OFS [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h30};
    localparam logic [31:0] IMG [6] = '{32'h2294, 32'h12, 32'h1100, 32'h0, 32'h0, 32'h0};
    // Frame list steps: written code, byte enables, expected code, expected entries
    localparam logic [31:0] FV [5][4] = '{'{32'h1, 32'h1, 32'h1, 32'h200},
        '{32'h2, 32'h1, 32'h2, 32'h100}, '{32'h3, 32'h1, 32'h2, 32'h100},
        '{32'h0, 32'h0, 32'h2, 32'h100}, '{32'h0, 32'h1, 32'h0, 32'h400}};
    cap_param_regs u_dut (
        .sys_clk               (sys_clk),
        .reset_n               (reset_n),
        .rd_en                 (rd_en),
        .wr_en                 (wr_en),
        .addr                  (addr),
        .byte_en               (byte_en),
        .wr_data               (wr_data),
        .rd_data_r             (rd_data_r),
        .rd_valid_r            (rd_valid_r),
        .port_owner_r          (port_owner_r),
        .port_present_r        (port_present_r),
        .port_power_ctrl_r     (port_power_ctrl_r),
        .frame_list_size_r     (frame_list_size_r),
        .frame_list_entries_r  (frame_list_entries_r),
        .wide_pointers_r       (wide_pointers_r),
        .iso_sched_threshold_r (iso_sched_threshold_r),
        .iso_full_frame_r      (iso_full_frame_r)
    );
    initial forever #4 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_en = 1;
        wr_en = 0;
        addr = a;
        @(posedge sys_clk);
        #1;
        chk("rd_valid_r", 1, rd_valid_r);
        chk("rd_data_r", e, rd_data_r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        wr_en = 1;
        rd_en = 0;
        addr = a;
        wr_data = d;
        byte_en = be;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle();
        rd_en = 0;
        wr_en = 0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 reset_n = 1;
        // Back-to-back reads of every image and an unmapped place
        for (int i = 0; i < 6; i++) rd(OFS[i], IMG[i]);
        idle();
        chk("port_owner_r", 60'h1100, port_owner_r);
        chk("port_present_r", 15'h000F, port_present_r);
        chk("port_power_ctrl_r", 1, port_power_ctrl_r);
        chk("iso_sched_threshold_r", 4'h1, iso_sched_threshold_r);
        chk("iso_full_frame_r", 0, iso_full_frame_r);
        chk("wide_pointers_r", 0, wide_pointers_r);
        $display("test images done");
        for (int i = 0; i < 4; i++) wr(OFS[i], 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 4; i++) rd(OFS[i], IMG[i]);
        idle();
        $display("test write ignore done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h20, FV[i][0] << 2, FV[i][1][3:0]);
            rd(8'h20, FV[i][2] << 2);
            idle();
            chk("frame_list_size_r", FV[i][2], frame_list_size_r);
            chk("frame_list_entries_r", FV[i][3], frame_list_entries_r);
            chk("frame_list_bytes", 1, {frame_list_entries_r, 2'h0} <= 13'h1000);
        end
        $display("test frame list done");
        wr(8'h20, 32'h4, 4'h1);
        idle();
        reset_n = 0;
        repeat (2) @(posedge sys_clk);
        #1 reset_n = 1;
        rd(8'h20, 32'h0);
        rd(8'h08, 32'h12);
        idle();
        chk("frame_list_entries_r", 11'h400, frame_list_entries_r);
        chk("frame_list_size_r", 0, frame_list_size_r);
        $display("test reset done");
        print_verdict();
    end
endmodule // cap_param_regs_tb_top
`default_nettype wire
